// File: rtl/difu_consts.svh
// difu_consts.svh: offsets, field positions and numeric constants of the arithmetic unit
// assumes inclusion by rtl/difu_top.sv only, not by rtl/difu_pkg.sv
`ifndef DIFU_CONSTS_SVH
`define DIFU_CONSTS_SVH

// ==========================================
// register offsets (byte addresses, low 8 bits)
`define DIFU_OFF_ACCA   8'h00
`define DIFU_OFF_ACCB   8'h04
`define DIFU_OFF_IDX1   8'h08
`define DIFU_OFF_IDX2   8'h0C
`define DIFU_OFF_IDX3   8'h10
`define DIFU_OFF_STAT   8'h14

// ==========================================
// status fields, reset values
`define DIFU_ST_OVF     0
`define DIFU_ST_CND_LO  1
`define DIFU_ST_CND_HI  2
`define DIFU_RST_WORD   32'h0000_0000
`define DIFU_RST_CND    2'h0

// ==========================================
// selector and condition codes
`define DIFU_SEL_NONE   2'h0
`define DIFU_SEL_A      2'h1
`define DIFU_SEL_D      2'h3
`define DIFU_CND_NEG    2'h1
`define DIFU_CND_ZERO   2'h2
`define DIFU_CND_POS    2'h3

// ==========================================
// float format and masks, fixed-point divide quotient limits
`define DIFU_EXP_BIAS   9'h040
`define DIFU_EXP_MAX    9'h07F
`define DIFU_MASK_SGL   64'hFFFF_FFFF_0000_0000
`define DIFU_MASK_DBL   64'hFFFF_FFFF_FFFF_FFF0
`define DIFU_QMAX_POS   64'h0000_0000_7FFF_FFFF
`define DIFU_QMAX_NEG   64'h0000_0000_8000_0000

`endif

// File: rtl/difu_pkg.sv
// difu_pkg: operation type of the divide, index and float unit
// assumes the decode logic presents one of these codes with each request
package difu_pkg;

  typedef enum logic [2:0] {
    DIFU_OP_DIV   = 3'b000,
    DIFU_OP_MODX  = 3'b001,
    DIFU_OP_FADD  = 3'b010,
    DIFU_OP_FADDU = 3'b011,
    DIFU_OP_FCMP  = 3'b100,
    DIFU_OP_FDIV  = 3'b101
  } difu_op_type;

endpackage

// File: rtl/difu_top.sv
// difu_top: divide, modify index and hex float add, compare and divide datapath
// assumes decode control presents one op per cycle with its fetched operand,
// and an AHB-Lite master reaches the accumulators, index and status words
//
// Contract
// RULE1 - divide 64-bit D by 32-bit word: quotient to B, remainder to A
// RULE2 - quotient sign algebraic, zero results positive, remainder takes dividend sign
// RULE3 - zero divisor sets overflow and leaves accumulators unchanged
// RULE4 - quotient wider than 32 bits sets overflow, accumulators undefined
// RULE5 - divide with C set gives condition 1/2/3 from quotient sign
// RULE6 - literal divisor is 18-bit field sign extended to 32 bits
// RULE7 - divisor larger than dividend gives zero quotient, dividend as remainder
// RULE8 - modify index adds unsigned index 1..3 to signed word, stores sum
// RULE9 - modify index condition: 1 leftmost one, 2 zero, 3 otherwise
// RULE10 - modify index sum beyond 32 bits sets overflow
// RULE11 - float selector 01 is single A, 11 double D; single leaves B
// RULE12 - align smaller exponent fraction right by hex digits until exponents match
// RULE13 - single add keeps last shifted-out digit as guard digit
// RULE14 - fraction carry shifts right a digit, bumps exponent; overflow terminates
// RULE15 - normalizing left shifts decrement exponent; underflow terminates
// RULE16 - zero fraction sum clears whole destination number
// RULE17 - normalized add: overflow or underflow sets overflow; underflow gives zero
// RULE18 - unnormalized add skips normalizing, overflow only on exponent overflow
// RULE19 - compare subtracts without normalizing, alters nothing, condition 1/2/3
// RULE20 - compare with C clear is a no-operation
// RULE21 - float divide with a zero operand terminates; zero divisor sets overflow
// RULE22 - quotient exponent is difference plus 64, plus one on right shift
// RULE23 - C clear leaves the condition indicator unchanged
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "difu_consts.svh"

module difu_top import difu_pkg::*; (
  // clock and reset
  input  logic        clock,
  input  logic        rstn,
  // ahb-lite slave
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic [31:0] hrdata,
  output logic        hreadyout,
  output logic        hresp,
  // operation request from decode
  input  logic        op_valid,
  input  difu_op_type op_code,
  input  logic [1:0]  op_sel,
  input  logic        op_cond,
  input  logic        op_lit,
  input  logic [17:0] op_addr,
  input  logic [63:0] op_mem,
  // status to control
  output logic        op_done,
  output logic        ovf_flag,
  output logic [1:0]  cond_code
);

  // ==========================================
  // state
  logic [31:0] acc_a_q, acc_b_q, hrdata_q;
  logic [31:0] idx_q [1:3];
  logic        ovf_q, done_q, wr_pend_q, hready_q;
  logic [1:0]  cond_q;
  logic [7:0]  wr_addr_q;

  function automatic logic [1:0] cnd_of(input logic neg, input logic zero);
    return zero ? `DIFU_CND_ZERO : (neg ? `DIFU_CND_NEG : `DIFU_CND_POS);
  endfunction

  function automatic logic [3:0] lead_zd(input logic [59:0] f);
    logic [3:0] n;
    logic       hit;
    n   = 4'h0;
    hit = 1'b0;
    for (int i = 14; i >= 0; i--) begin
      if (!hit && f[i*4 +: 4] == 4'h0) n = n + 4'h1;
      else hit = 1'b1;
    end
    return n;
  endfunction

  // ==========================================
  // fixed-point divide
  wire [31:0]  lit_w   = {{14{op_addr[17]}}, op_addr};             // [RULE6]
  wire [31:0]  dv_w    = op_lit ? lit_w : op_mem[63:32];
  wire [63:0]  dvd     = {acc_a_q, acc_b_q};
  wire [63:0]  n_mag   = dvd[63] ? -dvd : dvd;
  wire [31:0]  d_mag   = dv_w[31] ? -dv_w : dv_w;
  wire         div_zero = (dv_w == 32'h0);
  wire [63:0]  q_mag   = div_zero ? 64'h0 : n_mag / {32'h0, d_mag}; // [RULE1] [RULE7]
  wire [63:0]  r_full  = div_zero ? 64'h0 : n_mag % {32'h0, d_mag};
  wire         q_neg   = dvd[63] ^ dv_w[31];
  wire         div_big = q_neg ? (q_mag > `DIFU_QMAX_NEG) : (q_mag > `DIFU_QMAX_POS); // [RULE4]
  wire [31:0]  q_res   = q_neg ? -q_mag[31:0] : q_mag[31:0];       // [RULE2]
  wire [31:0]  r_res   = dvd[63] ? -r_full[31:0] : r_full[31:0];   // [RULE2]

  // ==========================================
  // modify index
  wire [31:0]  x_val   = (op_sel == `DIFU_SEL_NONE) ? 32'h0 : idx_q[op_sel];
  wire [33:0]  x_sum   = {2'b00, x_val} + {{2{dv_w[31]}}, dv_w};   // [RULE8]
  wire         x_ovf   = x_sum[33] | x_sum[32];                    // [RULE10]

  // ==========================================
  // float operands and alignment
  wire         dbl     = (op_sel == `DIFU_SEL_D);
  wire         fl_ok   = (op_sel == `DIFU_SEL_A) || dbl;          // [RULE11]
  wire [63:0]  f_mask  = dbl ? `DIFU_MASK_DBL : `DIFU_MASK_SGL;
  wire [6:0]   fa_e    = acc_a_q[30:24];
  wire [6:0]   fm_e    = op_mem[62:56];
  wire [55:0]  fa_f    = {acc_a_q[23:0], dbl ? acc_b_q : 32'h0};
  wire [55:0]  fm_f    = {op_mem[55:32], dbl ? op_mem[31:0] : 32'h0};
  wire         fm_s    = op_mem[63] ^ (op_code == DIFU_OP_FCMP);
  wire         a_big   = (fa_e >= fm_e);
  wire [6:0]   e_diff  = a_big ? fa_e - fm_e : fm_e - fa_e;
  wire [63:0]  sm_x    = {4'h0, a_big ? fm_f : fa_f, 4'h0};
  // a single barrel shift equals the digit-at-a-time walk; low digits past guard are masked
  wire [63:0]  sm_sh   = sm_x >> {e_diff, 2'b00};                  // [RULE12]
  wire [63:0]  al_a    = (a_big ? {4'h0, fa_f, 4'h0} : sm_sh) & f_mask; // [RULE13]
  wire [63:0]  al_m    = (a_big ? sm_sh : {4'h0, fm_f, 4'h0}) & f_mask; // [RULE13]
  wire [8:0]   e0      = {2'b00, a_big ? fa_e : fm_e};

  // ==========================================
  // fraction add, carry and normalize
  wire         same_s  = (acc_a_q[31] == fm_s);
  wire         a_ge    = (al_a >= al_m);
  wire [63:0]  f_sum   = same_s ? al_a + al_m : (a_ge ? al_a - al_m : al_m - al_a);
  wire         s_sign  = (same_s || a_ge) ? acc_a_q[31] : fm_s;
  wire         f_cry   = |f_sum[63:60];
  wire [63:0]  c_frac  = f_cry ? f_sum >> 4 : f_sum;               // [RULE14]
  wire [8:0]   c_exp   = e0 + {8'h00, f_cry};                      // [RULE14]
  wire         c_ovf   = (c_exp > `DIFU_EXP_MAX);                  // [RULE14]
  wire         f_zero  = (c_frac == 64'h0);                        // [RULE16]
  wire [3:0]   n_zd    = lead_zd(c_frac[59:0]);
  wire [63:0]  n_frac  = c_frac << {n_zd, 2'b00};                  // [RULE15]
  wire [8:0]   n_exp   = c_exp - {5'h00, n_zd};                    // [RULE15]
  wire         n_und   = n_exp[8];                                 // [RULE15]
  wire         norm    = (op_code == DIFU_OP_FADD);
  wire [63:0]  r_frac  = norm ? n_frac : c_frac;                   // [RULE18]
  wire [8:0]   r_exp   = norm ? n_exp : c_exp;
  wire [31:0]  fs_hi   = {s_sign, r_exp[6:0], r_frac[59:36]};
  wire [31:0]  fs_lo   = r_frac[35:4];

  // ==========================================
  // float divide
  wire         fa_zero = (fa_f == 56'h0);
  wire         fm_zero = (fm_f == 56'h0);
  wire [111:0] fq      = fm_zero ? 112'h0 : {fa_f, 56'h0} / {56'h0, fm_f};
  wire         fq_sh   = |fq[59:56];
  wire [55:0]  fq_f    = fq_sh ? fq[59:4] : fq[55:0];
  wire [8:0]   fq_e    = {2'b00, fa_e} - {2'b00, fm_e} + `DIFU_EXP_BIAS + {8'h00, fq_sh}; // [RULE22]
  wire         fq_und  = fq_e[8];
  wire         fq_ovf  = !fq_e[8] && (fq_e > `DIFU_EXP_MAX);
  wire         fq_s    = acc_a_q[31] ^ op_mem[63];

  // ==========================================
  // operation result select
  logic        w_hi, w_lo, w_x, s_ovf, c_en;
  logic [31:0] r_hi, r_lo;
  logic [1:0]  c_val;

  always_comb begin
    w_hi  = 1'b0;
    w_lo  = 1'b0;
    w_x   = 1'b0;
    s_ovf = 1'b0;
    c_en  = 1'b0;
    r_hi  = 32'h0;
    r_lo  = 32'h0;
    c_val = cond_q;
    if (op_valid) begin
      unique case (op_code)
        DIFU_OP_DIV: begin
          s_ovf = div_zero | div_big;                              // [RULE3] [RULE4]
          w_hi  = !div_zero;                                       // [RULE3]
          w_lo  = !div_zero;
          r_hi  = r_res;                                           // [RULE1]
          r_lo  = q_res;                                           // [RULE1]
          c_en  = op_cond && !div_zero;                            // [RULE5] [RULE23]
          c_val = cnd_of(q_res[31], q_res == 32'h0);               // [RULE5]
        end
        DIFU_OP_MODX: begin
          w_x   = (op_sel != `DIFU_SEL_NONE);                      // [RULE8]
          s_ovf = w_x && x_ovf;                                    // [RULE10]
          c_en  = op_cond && w_x;                                  // [RULE23]
          c_val = cnd_of(x_sum[31], x_sum[31:0] == 32'h0);         // [RULE9]
        end
        DIFU_OP_FADD, DIFU_OP_FADDU: begin
          if (fl_ok) begin
            // exponent overflow from the carry shift terminates with no write
            s_ovf = !f_zero && (c_ovf || (norm && n_und));         // [RULE17] [RULE18]
            w_hi  = f_zero || !c_ovf;                              // [RULE14]
            w_lo  = w_hi && dbl;                                   // [RULE11]
            r_hi  = (f_zero || (norm && n_und)) ? 32'h0 : fs_hi;   // [RULE16] [RULE17]
            r_lo  = (f_zero || (norm && n_und)) ? 32'h0 : fs_lo;   // [RULE16]
            c_en  = op_cond && w_hi;                               // [RULE23]
            c_val = cnd_of(r_hi[31], r_hi == 32'h0 && r_lo == 32'h0);
          end
        end
        DIFU_OP_FCMP: begin
          c_en  = fl_ok && op_cond;                                // [RULE20]
          c_val = cnd_of(s_sign, f_zero);                          // [RULE19]
        end
        DIFU_OP_FDIV: begin
          if (fl_ok) begin
            s_ovf = fm_zero || (!fa_zero && (fq_ovf || fq_und));   // [RULE21]
            w_hi  = !fa_zero && !fm_zero;                          // [RULE21]
            w_lo  = w_hi && dbl;                                   // [RULE11]
            r_hi  = fq_und ? 32'h0 : {fq_s, fq_e[6:0], fq_f[55:32]};
            r_lo  = fq_und ? 32'h0 : fq_f[31:0];
            c_en  = op_cond && w_hi;                               // [RULE23]
            c_val = cnd_of(r_hi[31], r_hi == 32'h0 && r_lo == 32'h0);
          end
        end
        default: begin
          c_en = 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // ahb-lite slave; an op in the same cycle wins over a bus write
  wire         a_take  = hsel && hready && htrans[1];
  wire [7:0]   ha      = haddr[7:0];
  wire         bw      = wr_pend_q && !op_valid;
  wire [31:0]  rd_val  = (ha == `DIFU_OFF_ACCA) ? acc_a_q :
                         (ha == `DIFU_OFF_ACCB) ? acc_b_q :
                         (ha == `DIFU_OFF_IDX1) ? idx_q[1] :
                         (ha == `DIFU_OFF_IDX2) ? idx_q[2] :
                         (ha == `DIFU_OFF_IDX3) ? idx_q[3] :
                         (ha == `DIFU_OFF_STAT) ? {29'h0, cond_q, ovf_q} : 32'h0;

  wire [31:0]  acc_a_d = w_hi ? r_hi : (bw && wr_addr_q == `DIFU_OFF_ACCA) ? hwdata : acc_a_q;
  wire [31:0]  acc_b_d = w_lo ? r_lo : (bw && wr_addr_q == `DIFU_OFF_ACCB) ? hwdata : acc_b_q;
  wire         bw_st   = bw && (wr_addr_q == `DIFU_OFF_STAT);
  // a hardware overflow set outranks a software clear in the same cycle
  wire         ovf_d   = s_ovf | (bw_st ? hwdata[`DIFU_ST_OVF] : ovf_q);
  wire [1:0]   cond_d  = c_en ? c_val : (bw_st ? hwdata[`DIFU_ST_CND_HI:`DIFU_ST_CND_LO] : cond_q);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      acc_a_q   <= `DIFU_RST_WORD;
      acc_b_q   <= `DIFU_RST_WORD;
      ovf_q     <= 1'b0;
      cond_q    <= `DIFU_RST_CND;
      done_q    <= 1'b0;
    end else begin
      acc_a_q   <= acc_a_d;
      acc_b_q   <= acc_b_d;
      ovf_q     <= ovf_d;
      cond_q    <= cond_d;
      done_q    <= op_valid;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q  <= 32'h0;
      hready_q  <= 1'b1;
    end else begin
      wr_pend_q <= a_take && hwrite;
      wr_addr_q <= a_take ? ha : wr_addr_q;
      hrdata_q  <= (a_take && !hwrite) ? rd_val : hrdata_q;
      hready_q  <= 1'b1;
    end
  end

  for (genvar g = 1; g <= 3; g++) begin : g_idx
    wire [7:0]  off  = `DIFU_OFF_IDX1 + 8'(4 * (g - 1));
    wire [31:0] nx_d = (w_x && op_sel == 2'(g)) ? x_sum[31:0] :   // [RULE8]
                       (bw && wr_addr_q == off) ? hwdata : idx_q[g];
    always_ff @(posedge clock) begin
      if (!rstn) idx_q[g] <= `DIFU_RST_WORD;
      else idx_q[g] <= nx_d;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp     = 1'b0 & hready_q;
  assign op_done   = done_q;
  assign ovf_flag  = ovf_q;
  assign cond_code = cond_q;

  // ==========================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  wire is_div = op_valid && op_code == DIFU_OP_DIV;
  wire div_ok = is_div && !div_zero && !div_big;
  wire is_fadd = op_valid && (op_code inside {DIFU_OP_FADD, DIFU_OP_FADDU}) && fl_ok;

  div_zero_a: assert property (is_div && div_zero |=> ovf_q && $stable(acc_a_q) && $stable(acc_b_q)) // [RULE3]
    else $error("zero divide altered accumulators");
  div_ident_a: assert property (div_ok |=>                         // [RULE1]
    $signed($past(dvd)) == $signed(acc_b_q) * $signed($past(dv_w)) + $signed(acc_a_q))
    else $error("divide result breaks dividend identity");
  div_rsign_a: assert property (div_ok |=> acc_a_q == 32'h0 || acc_a_q[31] == $past(dvd[63])) // [RULE2]
    else $error("remainder sign differs from dividend");
  div_cond_a: assert property (div_ok && op_cond |=>                // [RULE5]
    cond_q == (acc_b_q == 32'h0 ? 2'h2 : (acc_b_q[31] ? 2'h1 : 2'h3)))
    else $error("divide condition wrong");
  modx_ovf_a: assert property (op_valid && op_code == DIFU_OP_MODX && op_sel != 2'h0 |=> // [RULE10]
    ovf_q == ($past(ovf_q) || $past(x_ovf)))
    else $error("modify index overflow wrong");
  cond_hold_a: assert property (op_valid && !op_cond |=> $stable(cond_q)) // [RULE23]
    else $error("condition changed with C clear");
  fcmp_keep_a: assert property (op_valid && op_code == DIFU_OP_FCMP |=> $stable(acc_a_q) && $stable(acc_b_q)) // [RULE19]
    else $error("compare altered accumulators");
  fsingle_b_a: assert property (op_valid && op_code inside {DIFU_OP_FADD, DIFU_OP_FADDU, DIFU_OP_FDIV} // [RULE11]
    && op_sel == 2'h1 |=> $stable(acc_b_q))
    else $error("single float changed B");
  fdiv_zero_a: assert property (op_valid && op_code == DIFU_OP_FDIV && fl_ok && (fa_zero || fm_zero) |=> // [RULE21]
    $stable(acc_a_q) && ovf_q == ($past(ovf_q) || $past(fm_zero)))
    else $error("float divide by zero handling wrong");
  div_lit_a: assert property (is_div && op_lit |-> $signed(dv_w) == $signed(op_addr)) // [RULE6]
    else $error("literal divisor not sign extended");
  modx_sum_a: assert property (op_valid && op_code == DIFU_OP_MODX && op_sel != 2'h0 |=> // [RULE8]
    idx_q[$past(op_sel)] == $past(idx_q[op_sel]) + $past(dv_w))
    else $error("modify index sum wrong");
  modx_cond_a: assert property (op_valid && op_code == DIFU_OP_MODX && op_sel != 2'h0 && op_cond |=> // [RULE9]
    cond_q == (idx_q[$past(op_sel)] == 32'h0 ? 2'h2 : (idx_q[$past(op_sel)][31] ? 2'h1 : 2'h3)))
    else $error("modify index condition wrong");
  fadd_ovf_a: assert property (is_fadd && c_ovf && !f_zero |=>     // [RULE14]
    ovf_q && $stable(acc_a_q) && $stable(acc_b_q))
    else $error("float add carry overflow wrote a result");
  fadd_zero_a: assert property (is_fadd && f_zero |=>              // [RULE16]
    acc_a_q == 32'h0 && (!$past(dbl) || acc_b_q == 32'h0))
    else $error("zero sum left a nonzero number");
  fadd_und_a: assert property (is_fadd && norm && n_und && !f_zero |=> // [RULE17]
    ovf_q && acc_a_q == 32'h0)
    else $error("normalized underflow not forced to zero");
  fcmp_nop_a: assert property (op_valid && op_code == DIFU_OP_FCMP && !op_cond |=> // [RULE20]
    $stable(cond_q) && $stable(ovf_q))
    else $error("compare with C clear changed status");

  div_run_c:  cover property (div_ok ##1 op_done);
  fadd_cry_c: cover property (op_valid && norm && fl_ok && f_cry);
  fadd_und_c: cover property (op_valid && norm && fl_ok && n_und && !f_zero);
  modx_c:     cover property (op_valid && op_code == DIFU_OP_MODX && x_ovf);
  fcmp_eq_c:  cover property (op_valid && op_code == DIFU_OP_FCMP && op_cond && f_zero);

endmodule // difu_top

// File: sim/difu_ctl_model.sv
// difu_ctl_model: decode control and memory operand path feeding the op port
// assumes the unit takes a request at one edge and raises op_done for one cycle from that same edge
`timescale 1ns/1ps

module difu_ctl_model import difu_pkg::*; (
  // clock
  input  logic        clock,
  // op request
  output logic        op_valid,
  output difu_op_type op_code,
  output logic [1:0]  op_sel,
  output logic        op_cond,
  output logic        op_lit,
  output logic [17:0] op_addr,
  output logic [63:0] op_mem,
  // completion
  input  logic        op_done
);
  initial begin
    op_valid = 1'b0;
    op_code  = DIFU_OP_DIV;
    op_sel   = 2'h0;
    op_cond  = 1'b0;
    op_lit   = 1'b0;
    op_addr  = 18'h0_0000;
    op_mem   = 64'h0;
  end

  // ==========================================
  // one request, one cycle; operand lines inverted afterwards so stale data never looks valid
  task automatic issue(input difu_op_type c, input logic [1:0] s, input logic cc,
                       input logic [18:0] la, input logic [63:0] m, output logic done);
    @(posedge clock);
    op_valid <= 1'b1;
    op_code  <= c;
    op_sel   <= s;
    op_cond  <= cc;
    op_lit   <= la[18];
    op_addr  <= la[17:0];
    op_mem   <= m;
    @(posedge clock);
    op_valid <= 1'b0;
    op_addr  <= ~la[17:0];
    op_mem   <= ~m;
    #1 done = op_done;
  endtask
endmodule // difu_ctl_model

// File: sim/divide_index_float_unit_bench.sv
// divide_index_float_unit_bench: register tasks over ahb-lite and op sequences with expected results
// assumes zero wait state slave and one op request per call of the partner model
`timescale 1ns/1ps

module divide_index_float_unit_bench import difu_pkg::*;;
  logic clock = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic op_valid, op_cond, op_lit, op_done, ovf_flag, done;
  difu_op_type op_code;
  logic [1:0]  op_sel, cond_code;
  logic [17:0] op_addr;
  logic [63:0] op_mem;
  int errors = 0, n_checks = 0;

  always #12.5 clock = ~clock;

  difu_top difu_top_inst (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .op_valid(op_valid), .op_code(op_code), .op_sel(op_sel),
    .op_cond(op_cond), .op_lit(op_lit), .op_addr(op_addr), .op_mem(op_mem), .op_done(op_done),
    .ovf_flag(ovf_flag), .cond_code(cond_code));

  difu_ctl_model difu_ctl_model_inst (.clock(clock), .op_valid(op_valid), .op_code(op_code),
    .op_sel(op_sel), .op_cond(op_cond), .op_lit(op_lit), .op_addr(op_addr), .op_mem(op_mem),
    .op_done(op_done));

  // ==========================================
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================
  // bus cycles: address phase held until hready, then data phase held until hready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // ==========================================
  // one op case: preload, issue, read back; ab=0 leaves undefined contents unchecked
  task automatic t(input logic [31:0] a, b, input logic [2:0] ps, input difu_op_type o,
                   input logic [1:0] s, input logic c, input logic [18:0] la, input logic [63:0] m,
                   input logic [31:0] ea, eb, input logic [2:0] es, input logic ab);
    logic [7:0] aa;
    aa = (o == DIFU_OP_MODX) ? ({4'h0, s, 2'b00} + 8'h04) : `DIFU_OFF_ACCA;
    ahb(1'b1, aa, a, rd);
    ahb(1'b1, `DIFU_OFF_ACCB, b, rd);
    ahb(1'b1, `DIFU_OFF_STAT, {29'h0, ps}, rd);
    difu_ctl_model_inst.issue(o, s, c, la, m, done);
    chk("op_done", {31'h0, done}, 32'h1);
    ahb(1'b0, `DIFU_OFF_STAT, 32'h0, rd);
    chk("status", rd, {29'h0, es});
    chk("ovf_flag", {31'h0, ovf_flag}, {31'h0, es[0]});
    chk("cond_code", {30'h0, cond_code}, {30'h0, es[2:1]});
    if (ab) begin
      ahb(1'b0, aa, 32'h0, rd);
      chk("target", rd, ea);
      ahb(1'b0, `DIFU_OFF_ACCB, 32'h0, rd);
      chk("acc_b", rd, eb);
    end
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      ahb(1'b0, 8'(i * 4), 32'h0, rd);
      chk("reset word", rd, 32'h0);
    end
    chk("hresp", {31'h0, hresp}, 32'h0);
    // divide: sign cases, zero divisor, too-wide quotient, literal, small dividend, kept condition
    t(0, 100, 0, DIFU_OP_DIV, 0, 1, 0, {32'h7, 32'h0}, 2, 14, 3'h6, 1);
    t('1, 'hFFFFFF9C, 0, DIFU_OP_DIV, 0, 1, 0, {32'h7, 32'h0}, 'hFFFFFFFE, 'hFFFFFFF2, 3'h2, 1);
    t('1, 'hFFFFFFF2, 0, DIFU_OP_DIV, 0, 1, 0, {32'h7, 32'h0}, 0, 'hFFFFFFFE, 3'h2, 1);
    t(0, 100, 0, DIFU_OP_DIV, 0, 1, 0, 64'h0, 0, 100, 3'h1, 1);
    t(1, 0, 0, DIFU_OP_DIV, 0, 0, 0, {32'h1, 32'h0}, 0, 0, 3'h1, 0);
    t(0, 100, 0, DIFU_OP_DIV, 0, 1, 19'h7FFF9, 64'h0, 2, 'hFFFFFFF2, 3'h2, 1);
    t(0, 5, 0, DIFU_OP_DIV, 0, 1, 0, {32'h9, 32'h0}, 5, 0, 3'h4, 1);
    t(0, 100, 3'h2, DIFU_OP_DIV, 0, 0, 0, {32'h7, 32'h0}, 2, 14, 3'h2, 1);
    // modify index: selector codes 1 to 3, then sign, zero and carry-out results
    for (int i = 1; i < 4; i++) begin
      t(5, 7, 0, DIFU_OP_MODX, 2'(i), 1, 0, {32'hFFFFFFFD, 32'h0}, 2, 7, 3'h6, 1);
    end
    t('h80000000, 7, 0, DIFU_OP_MODX, 1, 1, 0, 64'h0, 'h80000000, 7, 3'h2, 1);
    t(3, 7, 0, DIFU_OP_MODX, 2, 1, 0, {32'hFFFFFFFD, 32'h0}, 0, 7, 3'h4, 1);
    t('1, 7, 0, DIFU_OP_MODX, 3, 0, 0, {32'h1, 32'h0}, 0, 7, 3'h1, 0);
    // float add: single keeps b, double pair, alignment, guard digit, carry, zero sum, underflow
    t('h41100000, 'h12345678, 0, DIFU_OP_FADD, 1, 1, 0, {32'h41100000, 32'h0}, 'h41200000, 'h12345678, 3'h6, 1);
    t('h41100000, 1, 0, DIFU_OP_FADD, 3, 1, 0, {32'h41100000, 32'h1}, 'h41200000, 2, 3'h6, 1);
    t('h42100000, 9, 0, DIFU_OP_FADD, 1, 1, 0, {32'h41100000, 32'h0}, 'h42110000, 9, 3'h6, 1);
    t('h41100001, 9, 0, DIFU_OP_FADD, 1, 1, 0, {32'hC2100000, 32'h0}, 'hC1EFFFFF, 9, 3'h2, 1);
    t('h41800000, 9, 0, DIFU_OP_FADD, 1, 1, 0, {32'h41800000, 32'h0}, 'h42100000, 9, 3'h6, 1);
    t('h41100000, 9, 0, DIFU_OP_FADD, 1, 1, 0, {32'hC1100000, 32'h0}, 0, 9, 3'h4, 1);
    t('h00100001, 9, 0, DIFU_OP_FADD, 1, 1, 0, {32'h80100000, 32'h0}, 0, 9, 3'h5, 1);
    t('h41100000, 9, 0, DIFU_OP_FADDU, 1, 1, 0, {32'hC1080000, 32'h0}, 'h41080000, 9, 3'h6, 1);
    t('h41100000, 9, 0, DIFU_OP_FADD, 2, 1, 0, {32'h41100000, 32'h0}, 'h41100000, 9, 3'h0, 1);
    // compare: greater, equal, less leave operands alone; c clear does nothing
    for (int i = 1; i < 4; i++) begin
      t('h41200000, 9, 0, DIFU_OP_FCMP, 1, 1, 0, {8'h41, 4'(i), 52'h0}, 'h41200000, 9, 3'(8 - 2 * i), 1);
    end
    t('h41200000, 9, 3'h4, DIFU_OP_FCMP, 1, 0, 0, {32'h41100000, 32'h0}, 'h41200000, 9, 3'h4, 1);
    // float divide: zero divisor, zero dividend, quotient needing a right shift
    t('h41400000, 9, 0, DIFU_OP_FDIV, 1, 1, 0, 64'h0, 'h41400000, 9, 3'h1, 1);
    t(0, 9, 0, DIFU_OP_FDIV, 1, 1, 0, {32'h41200000, 32'h0}, 0, 9, 3'h0, 1);
    t('h41400000, 9, 0, DIFU_OP_FDIV, 1, 1, 0, {32'h41200000, 32'h0}, 'h41200000, 9, 3'h6, 1);
    wrap_up();
  end
endmodule // divide_index_float_unit_bench
